// ### wwc_core_model.sv
// Processor core model: oscillator, clear-watchdog and halt instructions
`timescale 1ns/1ps
`default_nettype none
module wwc_core_model #(
    parameter int GAP = 100
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic alive_i,
    input wire logic halt_req_i,
    input wire logic device_reset_i,
    output logic osc_o,
    output logic wdt_clear_o,
    output logic sleep_entry_o,
    output logic [7:0] n_resets_o
);
    logic [7:0] gap_q;
    logic halt_q;
    // Fast stand-in for the slow oscillator: one rising edge every two clocks
    always_ff @(posedge clk_i) begin
        osc_o <= rst_i ? 1'b0 : !osc_o;
    end
    // Clear instruction when keep-alive starts, then every GAP cycles
    always_ff @(posedge clk_i) begin
        if (rst_i || !alive_i) begin
            gap_q <= 8'h00;
        end else begin
            gap_q <= (gap_q == 8'(GAP - 1)) ? 8'h00 : gap_q + 8'h01;
        end
        wdt_clear_o <= !rst_i && alive_i && gap_q == 8'h00;
    end
    // One halt instruction per rising request
    always_ff @(posedge clk_i) begin
        halt_q <= halt_req_i;
        sleep_entry_o <= !rst_i && halt_req_i && !halt_q;
        n_resets_o <= rst_i ? 8'h00 : n_resets_o + 8'(device_reset_i);
    end
endmodule // wwc_core_model
`default_nettype wire

// ### wwc_pkg.sv
// Package with register map, field layout, reset values and timing of the watchdog block
package wwc_pkg;

    // Register byte addresses on the Wishbone slave
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_RCF = 8'h04;
    localparam logic [7:0] ADDR_WAKE_EN = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0c;
    localparam logic [7:0] ADDR_IST = 8'h10;
    localparam logic [7:0] ADDR_IMASK = 8'h14;

    // watchdog_control layout and values
    localparam int KEY_MSB = 7;
    localparam int KEY_LSB = 3;
    localparam int SEL_MSB = 2;
    localparam logic [4:0] KEY_EN = 5'h0a;
    localparam logic [4:0] KEY_DIS = 5'h15;
    localparam logic [7:0] CTRL_RST = 8'h53;

    // Bit positions in reset_cause_flags, status and interrupt registers
    localparam int RCF_WRF_BIT = 0;
    localparam int STAT_TO_BIT = 0;
    localparam int STAT_PD_BIT = 1;
    localparam int STAT_HALT_BIT = 2;
    localparam int IRQ_TO_BIT = 0;
    localparam int IRQ_KEY_BIT = 1;
    localparam int IRQ_WAKE_BIT = 2;
    localparam int IRQ_W = 3;

    // Widths
    localparam int CNT_W = 18;
    localparam int PA_W = 8;
    localparam int INT_W = 8;
    localparam int SRST_W = 8;

    // Timing: soft reset delay in ns and its cycle count, rounded up
    localparam int CLK_PERIOD_NS = 100;
    localparam int SRESET_NS = 20000;
    localparam int SRESET_CYC = (SRESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [SRST_W-1:0] SRST_LAST = SRST_W'(SRESET_CYC - 1);

    typedef enum logic [0:0] {
        WWC_RUN = 1'b0,
        WWC_HALT = 1'b1
    } wwc_pwr_t;

    // A key other than the two valid ones
    function automatic logic key_invalid(input logic [4:0] key);
        key_invalid = (key != KEY_EN) && (key != KEY_DIS);
    endfunction

    // Time-out exponent for each select code
    function automatic logic [4:0] tmo_exp(input logic [2:0] sel);
        case (sel)
            3'h0: tmo_exp = 5'h08;
            3'h1: tmo_exp = 5'h0a;
            3'h2: tmo_exp = 5'h0c;
            3'h3: tmo_exp = 5'h0e;
            3'h4: tmo_exp = 5'h0f;
            3'h5: tmo_exp = 5'h10;
            3'h6: tmo_exp = 5'h11;
            default: tmo_exp = 5'h12;
        endcase
    endfunction

    // True when the next increment first sets the selected bit (carry for 2^18)
    function automatic logic wdt_ovf(input logic [CNT_W-1:0] cnt, input logic [2:0] sel);
        logic [CNT_W:0] sum;
        logic [CNT_W:0] cur;
        sum = {1'b0, cnt} + {{CNT_W{1'b0}}, 1'b1};
        cur = {1'b0, cnt};
        wdt_ovf = sum[tmo_exp(sel)] && !cur[tmo_exp(sel)];
    endfunction

endpackage

// ### wwc_watchdog_wake.sv
// Watchdog timer with keyed enable, delayed soft reset and power-down wake-up control
//
// Our own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Counter advances only on rising edges of the low-speed oscillator input.
// - Select codes 0..7 give 2^8,10,12,14,15,16,17,18 oscillator periods.
// - Key 01010 enables the watchdog, key 10101 disables it.
// - Any other key value causes a full reset after the soft reset delay.
// - After power-on the key enables and the select code is 011.
// - Invalid-key reset sets a sticky flag cleared only by software writing zero.
// - Overflow while running resets the device and sets the time-out flag.
// - Overflow while halted sets time-out flag, resets only PC and stack pointer.
// - Invalid key write, clear instruction or sleep entry clears the counter.
// - Sleep entry sets power-down flag; power-up or clear instruction clears it.
// - Halted device wakes on Port A falling edge, interrupt or overflow.
// - Per-pin Port A wake enable; pin wake resumes after the halt.
// - Disabled interrupt or full stack resumes after halt; interrupt stays pending.
// - Enabled interrupt with stack room performs normal interrupt entry on wake.
// - Interrupt already requested before halt cannot wake the device.
// - Sleep entry clears the counter; it counts on only if enabled.
// - Sleep entry clears the time-out flag as the power-down flag is set.
module wwc_watchdog_wake
    import wwc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic low_speed_osc_i,
    input wire logic wdt_clear_i,
    input wire logic sleep_entry_i,
    input wire logic [PA_W-1:0] porta_i,
    input wire logic [INT_W-1:0] int_req_i,
    input wire logic [INT_W-1:0] int_en_i,
    input wire logic stack_full_i,
    output logic device_reset_o,
    output logic pc_sp_reset_o,
    output logic wake_o,
    output logic resume_next_o,
    output logic int_entry_o,
    output logic [INT_W-1:0] int_hold_o,
    output logic halted_o,
    output logic irq_o
);

    logic wb_ack_q;
    logic [31:0] wb_dat_q;
    logic [7:0] ctrl_q;
    logic [PA_W-1:0] wake_en_q;
    logic [IRQ_W-1:0] ist_q;
    logic [IRQ_W-1:0] imask_q;
    logic [SRST_W-1:0] srst_cnt_q;
    logic [CNT_W-1:0] cnt_q;
    logic lso_q;
    logic to_q;
    logic pd_q;
    logic wrf_q;
    logic dev_rst_q;
    logic pcsp_q;
    logic wake_q;
    logic resume_q;
    logic int_entry_q;
    logic [INT_W-1:0] hold_q;
    logic [INT_W-1:0] blk_q;
    logic [PA_W-1:0] pa_q;
    wwc_pwr_t pwr_q;

    logic wb_acc;
    logic wb_wr;
    logic wr_ctrl;
    logic new_key_bad;
    logic key_bad;
    logic wdt_en;
    logic lso_tick;
    logic ovf_w;
    logic key_fire;
    logic halted;
    logic sleep_go;
    logic pa_wake;
    logic [INT_W-1:0] int_new;
    logic int_wake;
    logic int_ok;
    logic wake_go;
    logic [INT_W-1:0] hold_set;
    logic [IRQ_W-1:0] ist_set;
    logic [IRQ_W-1:0] ist_clr;
    logic [31:0] rd_data;

    // Wishbone decode: one access per request, answered one cycle later
    assign wb_acc = wb_cyc_i && wb_stb_i && !wb_ack_q;
    assign wb_wr = wb_acc && wb_we_i && wb_sel_i[0];
    assign wr_ctrl = wb_wr && (wb_adr_i == ADDR_CTRL);
    assign new_key_bad = wr_ctrl && key_invalid(wb_dat_i[KEY_MSB:KEY_LSB]);

    assign key_bad = key_invalid(ctrl_q[KEY_MSB:KEY_LSB]);
    assign wdt_en = ctrl_q[KEY_MSB:KEY_LSB] == KEY_EN;
    assign lso_tick = low_speed_osc_i && !lso_q;
    assign ovf_w = lso_tick && wdt_en && wdt_ovf(cnt_q, ctrl_q[SEL_MSB:0]);
    assign key_fire = key_bad && (srst_cnt_q == SRST_LAST) && !dev_rst_q;
    assign halted = pwr_q == WWC_HALT;
    assign sleep_go = sleep_entry_i && !halted;

    // Wake sources, with requests pending at halt entry masked off
    assign pa_wake = |(pa_q & ~porta_i & wake_en_q);
    assign int_new = int_req_i & ~blk_q;
    assign int_wake = |int_new;
    assign int_ok = (|(int_new & int_en_i)) && !stack_full_i;
    assign wake_go = halted && (pa_wake || int_wake || ovf_w);
    assign hold_set = (wake_go && !ovf_w) ? (int_new & ~(int_en_i & {INT_W{~stack_full_i}}))
                                          : {INT_W{1'b0}};

    assign ist_set = {wake_go, key_fire, ovf_w};
    assign ist_clr = (wb_wr && (wb_adr_i == ADDR_IST)) ? wb_dat_i[IRQ_W-1:0] : {IRQ_W{1'b0}};

    always_comb begin
        case (wb_adr_i)
            ADDR_CTRL: rd_data = {24'h000000, ctrl_q};
            ADDR_RCF: rd_data = {31'h00000000, wrf_q};
            ADDR_WAKE_EN: rd_data = {24'h000000, wake_en_q};
            ADDR_STAT: rd_data = {29'h00000000, halted, pd_q, to_q};
            ADDR_IST: rd_data = {29'h00000000, ist_q};
            ADDR_IMASK: rd_data = {29'h00000000, imask_q};
            default: rd_data = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_q <= 1'b0;
            wb_dat_q <= 32'h00000000;
        end else begin
            wb_ack_q <= wb_acc;
            if (wb_acc && !wb_we_i) begin
                wb_dat_q <= rd_data;
            end
        end
    end

    // watchdog_control: power-on value, restored by every full reset
    always_ff @(posedge clk_i) begin
        if (rst_i || dev_rst_q) begin
            ctrl_q <= CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_en_q <= {PA_W{1'b0}};
            imask_q <= {IRQ_W{1'b0}};
        end else if (wb_wr && (wb_adr_i == ADDR_WAKE_EN)) begin
            wake_en_q <= wb_dat_i[PA_W-1:0];
        end else if (wb_wr && (wb_adr_i == ADDR_IMASK)) begin
            imask_q <= wb_dat_i[IRQ_W-1:0];
        end
    end

    // Soft reset delay runs while the key is invalid; a valid key cancels it
    always_ff @(posedge clk_i) begin
        if (rst_i || dev_rst_q || !key_bad) begin
            srst_cnt_q <= {SRST_W{1'b0}};
        end else if (srst_cnt_q != SRST_LAST) begin
            srst_cnt_q <= srst_cnt_q + {{(SRST_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lso_q <= 1'b0;
        end else begin
            lso_q <= low_speed_osc_i;
        end
    end

    // Watchdog counter
    always_ff @(posedge clk_i) begin
        if (rst_i || dev_rst_q || wdt_clear_i || sleep_go || new_key_bad || ovf_w) begin
            cnt_q <= {CNT_W{1'b0}};
        end else if (lso_tick && wdt_en) begin
            cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // Time-out and power-down flags; a setting event wins over a clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            to_q <= 1'b0;
        end else if (ovf_w) begin
            to_q <= 1'b1;
        end else if (sleep_go) begin
            to_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pd_q <= 1'b0;
        end else if (sleep_go) begin
            pd_q <= 1'b1;
        end else if (wdt_clear_i) begin
            pd_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wrf_q <= 1'b0;
        end else if (key_fire) begin
            wrf_q <= 1'b1;
        end else if (wb_wr && (wb_adr_i == ADDR_RCF) && !wb_dat_i[RCF_WRF_BIT]) begin
            wrf_q <= 1'b0;
        end
    end

    // Full reset request and partial PC/stack reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dev_rst_q <= 1'b0;
            pcsp_q <= 1'b0;
        end else begin
            dev_rst_q <= key_fire || (ovf_w && !halted);
            pcsp_q <= ovf_w && halted;
        end
    end

    // Power state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwr_q <= WWC_RUN;
        end else begin
            case (pwr_q)
                WWC_RUN: begin
                    if (sleep_go && !dev_rst_q) begin
                        pwr_q <= WWC_HALT;
                    end
                end
                WWC_HALT: begin
                    if (wake_go || dev_rst_q) begin
                        pwr_q <= WWC_RUN;
                    end
                end
                default: pwr_q <= WWC_RUN;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            blk_q <= {INT_W{1'b0}};
            pa_q <= {PA_W{1'b0}};
        end else begin
            pa_q <= porta_i;
            if (sleep_go) begin
                blk_q <= int_req_i;
            end
        end
    end

    // Wake outcome: overflow, then interrupt entry, else resume after halt
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_q <= 1'b0;
            int_entry_q <= 1'b0;
            resume_q <= 1'b0;
        end else begin
            wake_q <= wake_go;
            int_entry_q <= wake_go && !ovf_w && int_ok;
            resume_q <= wake_go && !ovf_w && !int_ok;
        end
    end

    // Pending hold per interrupt line, released once it can be serviced
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_q <= {INT_W{1'b0}};
        end else begin
            hold_q <= (hold_q & ~(int_en_i & {INT_W{~stack_full_i}})) | hold_set;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ist_q <= {IRQ_W{1'b0}};
        end else begin
            ist_q <= (ist_q & ~ist_clr) | ist_set;
        end
    end

    assign wb_ack_o = wb_ack_q;
    assign wb_dat_o = wb_dat_q;
    assign device_reset_o = dev_rst_q;
    assign pc_sp_reset_o = pcsp_q;
    assign wake_o = wake_q;
    assign resume_next_o = resume_q;
    assign int_entry_o = int_entry_q;
    assign int_hold_o = hold_q;
    assign halted_o = halted;
    assign irq_o = |(ist_q & imask_q);

    srst_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (key_bad && srst_cnt_q == SRST_LAST && !dev_rst_q) |=> device_reset_o && wrf_q)
        else $error("invalid key did not reset after delay");

    wrf_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wrf_q && !(wb_wr && wb_adr_i == ADDR_RCF)) |=> wrf_q)
        else $error("reset flag cleared by hardware");

    run_ovf_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ovf_w && !halted) |=> device_reset_o && to_q && !pc_sp_reset_o)
        else $error("overflow while running did not reset");

    halt_ovf_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ovf_w && halted) |=> pc_sp_reset_o && !device_reset_o && to_q && wake_o)
        else $error("overflow while halted handled wrongly");

    sleep_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (sleep_go && !ovf_w && !dev_rst_q) |=> pd_q && !to_q && cnt_q == '0 && halted)
        else $error("sleep entry flags wrong");

    clear_instr_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wdt_clear_i && !sleep_go) |=> !pd_q && cnt_q == '0)
        else $error("clear instruction did not clear");

    disabled_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !wdt_en |=> ($stable(cnt_q) || cnt_q == '0) && !$past(ovf_w))
        else $error("disabled watchdog counted");

    blocked_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (halted && int_new == '0 && !pa_wake && !ovf_w) |=> !wake_o)
        else $error("device woke without a fresh source");

    int_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wake_go && !ovf_w && int_ok) |=> int_entry_o && !resume_next_o ##1 !int_entry_o)
        else $error("interrupt entry not taken");

    disabled_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl_q[KEY_MSB:KEY_LSB] == KEY_DIS) |=> !device_reset_o && !pc_sp_reset_o)
        else $error("disabled watchdog raised a reset");

    reset_ctrl_a: assert property (@(posedge clk_i) disable iff (rst_i)
        device_reset_o |=> ctrl_q == CTRL_RST)
        else $error("control not restored after full reset");

    key_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        new_key_bad |=> cnt_q == '0)
        else $error("invalid key write did not clear counter");

    osc_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !lso_tick |=> ($stable(cnt_q) || cnt_q == '0))
        else $error("counter moved without an oscillator edge");

    wake_exit_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wake_go |=> wake_o && !halted_o)
        else $error("wake source did not end the halt");

    pin_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (halted && pa_wake && !ovf_w && int_new == '0) |=> resume_next_o && !int_entry_o)
        else $error("pin wake did not resume after halt");

    held_int_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wake_go && !ovf_w && !int_ok && int_wake) |=> resume_next_o && int_hold_o != '0)
        else $error("unserviceable wake interrupt not held");

endmodule // wwc_watchdog_wake

`default_nettype wire

// ### wwc_watchdog_wake_tb.sv
// Self-checking testbench of the watchdog and wake-up block
`timescale 1ns/1ps
`default_nettype none
module wwc_watchdog_wake_tb;
    import wwc_pkg::*;
    logic clk_i = 1'b0, rst_i, cyc, stb, we, alive, halt_req, stack_full, osc, clr, slp;
    logic wb_ack_o, device_reset_o, pc_sp_reset_o, wake_o, resume_next_o, int_entry_o;
    logic halted_o, irq_o;
    logic [7:0] adr, porta, int_req, int_en, int_hold_o, n_rst, r;
    logic [31:0] wdat, wb_dat_o;
    int num_errors = 0, n_compared = 0, n, lo;
    always #50 clk_i = !clk_i;
    wwc_watchdog_wake dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .low_speed_osc_i(osc), .wdt_clear_i(clr), .sleep_entry_i(slp),
        .porta_i(porta), .int_req_i(int_req), .int_en_i(int_en), .stack_full_i(stack_full),
        .device_reset_o(device_reset_o), .pc_sp_reset_o(pc_sp_reset_o), .wake_o(wake_o),
        .resume_next_o(resume_next_o), .int_entry_o(int_entry_o), .int_hold_o(int_hold_o),
        .halted_o(halted_o), .irq_o(irq_o));
    wwc_core_model core (.clk_i(clk_i), .rst_i(rst_i), .alive_i(alive), .halt_req_i(halt_req),
        .device_reset_i(device_reset_o), .osc_o(osc), .wdt_clear_o(clr), .sleep_entry_o(slp),
        .n_resets_o(n_rst));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        r = wb_dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
        wb(1'b0, a, 8'h00);
        chk(r, e, nm);
    endtask
    task automatic wait_ev(input int which, input int lim);
        logic [2:0] v;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
            v = {wake_o, pc_sp_reset_o, device_reset_o};
        end while (v[which] !== 1'b1 && n < lim);
    endtask
    task automatic kick(input logic h);
        @(posedge clk_i);
        if (h) halt_req <= 1'b1;
        else alive <= 1'b1;
        @(posedge clk_i);
        halt_req <= 1'b0;
        alive <= 1'b0;
    endtask
    task automatic t_regs();
        rdc(ADDR_CTRL, 8'h53, "ctrl reset");
        rdc(ADDR_RCF, 8'h00, "rcf reset");
        rdc(ADDR_STAT, 8'h00, "status reset");
        rdc(8'h1c, 8'h00, "unmapped");
        wb(1'b1, ADDR_WAKE_EN, 8'h01);
        rdc(ADDR_WAKE_EN, 8'h01, "wake enable");
    endtask
    task automatic t_tmo();
        for (int s = 0; s < 3; s++) begin
            wb(1'b1, ADDR_CTRL, {KEY_EN, 3'(s)});
            kick(1'b0);
            wait_ev(0, 9000);
            lo = 2 << (8 + 2 * s);
            chk(n >= lo - 2 && n <= lo + 6, 1, "timeout span");
            rdc(ADDR_STAT, 8'h01, "timeout flag");
            rdc(ADDR_CTRL, 8'h53, "ctrl after reset");
        end
    endtask
    task automatic t_sleep();
        wb(1'b1, ADDR_CTRL, {KEY_EN, 3'h0});
        lo = n_rst;
        @(posedge clk_i);
        alive <= 1'b1;
        repeat (1500) @(posedge clk_i);
        alive <= 1'b0;
        chk(n_rst, lo, "no reset while cleared");
        kick(1'b1);
        rdc(ADDR_STAT, 8'h06, "halt flags");
        wait_ev(1, 700);
        chk(n >= 500 && n <= 518, 1, "halted overflow span");
        chk({wake_o, device_reset_o, halted_o}, 3'b100, "overflow wake");
        rdc(ADDR_STAT, 8'h03, "flags after wake");
        kick(1'b0);
        rdc(ADDR_STAT, 8'h01, "pd cleared");
        wb(1'b1, ADDR_CTRL, {KEY_DIS, 3'h0});
    endtask
    task automatic t_key();
        chk(irq_o, 1'b0, "irq masked");
        lo = n_rst;
        repeat (1200) @(posedge clk_i);
        chk(n_rst, lo, "disabled");
        wb(1'b1, ADDR_IMASK, 8'h02);
        wb(1'b1, ADDR_CTRL, 8'h00);
        wait_ev(0, 400);
        chk(n >= SRESET_CYC - 10 && n <= SRESET_CYC + 10, 1, "key reset delay");
        @(negedge clk_i);
        chk(irq_o, 1'b1, "irq raised");
        rdc(ADDR_RCF, 8'h01, "key flag");
        wb(1'b1, ADDR_RCF, 8'h01);
        rdc(ADDR_RCF, 8'h01, "key flag kept");
        wb(1'b1, ADDR_RCF, 8'h00);
        rdc(ADDR_RCF, 8'h00, "key flag cleared");
        wb(1'b1, ADDR_IST, 8'h02);
        @(negedge clk_i);
        chk(irq_o, 1'b0, "irq cleared");
        wb(1'b1, ADDR_CTRL, {KEY_DIS, 3'h0});
    endtask
    task automatic t_wake();
        @(posedge clk_i);
        int_req <= 8'h08;
        kick(1'b1);
        porta <= 8'hfd;
        wait_ev(2, 40);
        chk(halted_o, 1'b1, "no wake");
        @(posedge clk_i);
        porta <= 8'hfc;
        wait_ev(2, 10);
        chk({wake_o, resume_next_o, int_entry_o}, 3'b110, "pin wake");
        @(posedge clk_i);
        porta <= 8'hff;
        int_req <= 8'h00;
        kick(1'b1);
        @(posedge clk_i);
        int_en <= 8'h04;
        int_req <= 8'h04;
        wait_ev(2, 10);
        chk({wake_o, resume_next_o, int_entry_o}, 3'b101, "int entry");
        @(posedge clk_i);
        int_req <= 8'h00;
        int_en <= 8'h20;
        stack_full <= 1'b1;
        kick(1'b1);
        @(posedge clk_i);
        int_req <= 8'h20;
        wait_ev(2, 10);
        chk({wake_o, resume_next_o, int_entry_o}, 3'b110, "stack full");
        @(negedge clk_i);
        chk(int_hold_o, 8'h20, "held");
        @(posedge clk_i);
        stack_full <= 1'b0;
        repeat (3) @(negedge clk_i);
        chk(int_hold_o, 8'h00, "released");
    endtask
    task automatic wrap_up();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk_i);
        num_errors++;
        wrap_up();
    end
    initial begin
        {rst_i, cyc, stb, we, alive, halt_req, stack_full} = 7'h40;
        {adr, int_req, int_en, wdat, porta} = {24'h0, 32'h0, 8'hff};
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_tmo();
        t_sleep();
        t_key();
        t_wake();
        wrap_up();
    end
endmodule // wwc_watchdog_wake_tb
`default_nettype wire
